// ---- verilog/qei_map.svh ----
// Register offsets, field positions, reset values and widths of the encoder block.
// Assumes a 16-bit register port addressed in words.
`ifndef QEI_MAP_SVH
`define QEI_MAP_SVH
`define QEI_ADDR_W        4
`define QEI_OFS_CTRL      4'h0
`define QEI_OFS_IOC       4'h1
`define QEI_OFS_STAT      4'h2
`define QEI_OFS_POSH      4'h3
`define QEI_OFS_POSL      4'h4
`define QEI_OFS_IRQMASK   4'h5
`define QEI_CTRL_RST      16'h0000
`define QEI_IOC_RST       16'h0000
`define QEI_STAT_RST      16'h0000
`define QEI_CTRL_EN       15
`define QEI_CTRL_SIDL     13
`define QEI_CTRL_PIM_HI   12
`define QEI_CTRL_PIM_LO   10
`define QEI_CTRL_IMV_HI   9
`define QEI_CTRL_IMV_LO   8
`define QEI_CTRL_DIV_HI   6
`define QEI_CTRL_DIV_LO   4
`define QEI_CTRL_POL      3
`define QEI_CTRL_GATE     2
`define QEI_CTRL_CCM_HI   1
`define QEI_CTRL_CCM_LO   0
`define QEI_IOC_SWAP      8
`define QEI_IOC_HOMPOL    7
`define QEI_IOC_IDXPOL    6
`define QEI_IOC_BPOL      5
`define QEI_IOC_APOL      4
`define QEI_IOC_WMASK     16'hFFF0
`define QEI_STAT_WMASK    16'h3FFF
`define QEI_ST_PCI        7
`define QEI_ST_PCIEN      6
`define QEI_ST_HOM        3
`define QEI_ST_HOMEN      2
`define QEI_ST_IDX        1
`define QEI_ST_IDXEN      0
`define QEI_STAT_FLAGS    16'h2AAA
`endif

// ---- verilog/qei_pkg.sv ----
// Types shared by the encoder block.
// Assumes qei_map.svh supplies the numbers.
package qei_pkg;
   typedef enum logic [1:0] {
      QEI_CCM_QUAD = 2'b00,
      QEI_CCM_EXTDIR = 2'b01,
      QEI_CCM_EXTCLK = 2'b10,
      QEI_CCM_TIMER = 2'b11
   } qei_ccm_e;
   typedef enum logic [2:0] {
      QEI_PIM_NONE = 3'b000,
      QEI_PIM_EVERY = 3'b001,
      QEI_PIM_NEXT = 3'b010,
      QEI_PIM_HOMEIDX = 3'b011,
      QEI_PIM_HOME2 = 3'b100,
      QEI_PIM_CMP = 3'b101,
      QEI_PIM_MOD = 3'b110,
      QEI_PIM_RSV = 3'b111
   } qei_pim_e;
   typedef struct packed {
      logic home;
      logic index;
      logic phase_b;
      logic phase_a;
   } qei_pins_s;
   typedef enum {QEI_HS_WAIT, QEI_HS_IDX1, QEI_HS_IDX2} qei_home_e;
endpackage : qei_pkg

// ---- verilog/qei_core.sv ----
// Quadrature encoder interface: pin decode, 32-bit position counter, status and irq.
// Assumes pins are asynchronous and a one-cycle register port on sys_clk.
//
// Overview of operation
// - Mode 00 counts every A/B edge
// - Mode 01 counts pulses, direction from pin
// - Mode 11 timer; mode 10 external clock
// - Modes 10/11 timers, ignore init mode
// - Mode 00 clears counter on index match
// - Polarity bit makes default direction negative
// - Gate enable lets gate pin stop counting
// - A/B levels readable after inversion and swap
// - Index level readable after inversion
// - Index event sets sticky index flag
// - Index flag has interrupt enable bit
// - Reinit flag only in init modes 011/100
// - Counter bits 31:16 form high word register
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "qei_map.svh"
module qei_core (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   // Register port
   input  wire logic [`QEI_ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [15:0]            reg_rdata,
   // Processor state
   input  wire logic                   cpu_idle,
   // Encoder pins
   input  wire logic                   phase_a_input,
   input  wire logic                   phase_b_input,
   input  wire logic                   index_input,
   input  wire logic                   home_input,
   input  wire logic                   gate_input,
   // Interrupt
   output logic                        irq
);
   logic [15:0] encoder_control;
   logic [15:0] encoder_io_control;
   logic [15:0] encoder_status;
   logic [15:0] irq_mask;
   logic [31:0] position_counter;
   logic [15:0] position_high_word;
   logic [31:0] init_capture_register;
   qei_pkg::qei_pins_s pin_s1;
   qei_pkg::qei_pins_s pin_s2;
   qei_pkg::qei_pins_s pin_q;
   qei_pkg::qei_pins_s pin_l;
   logic        gate_s1;
   logic        gate_s2;
   logic        phase_a_level;
   logic        phase_b_level;
   logic        index_level;
   logic        home_level;
   logic        run;
   logic        step;
   logic        dir_up;
   logic        idx_rise;
   logic        home_rise;
   logic        idx_match;
   logic        next_flag_pci;
   logic        do_clear;
   logic        do_load;
   logic        armed;
   logic [7:0]  pre_cnt;
   logic        pre_tick;
   qei_pkg::qei_home_e home_st;
   qei_pkg::qei_ccm_e  counter_control_mode;
   qei_pkg::qei_pim_e  pim;

   assign counter_control_mode = qei_pkg::qei_ccm_e'(encoder_control[`QEI_CTRL_CCM_HI:`QEI_CTRL_CCM_LO]);
   assign pim = qei_pkg::qei_pim_e'(encoder_control[`QEI_CTRL_PIM_HI:`QEI_CTRL_PIM_LO]);

   // Two-stage synchronisers; only stage two is read
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pin_s1  <= '0;
         pin_s2  <= '0;
         gate_s1 <= 1'b0;
         gate_s2 <= 1'b0;
      end else begin
         pin_s1  <= '{home_input, index_input, phase_b_input, phase_a_input};
         pin_s2  <= pin_s1;
         gate_s1 <= gate_input;
         gate_s2 <= gate_s1;
      end
   end

   // Polarity and swap before decoding
   always_comb begin
      phase_a_level = (encoder_io_control[`QEI_IOC_SWAP] ? pin_s2.phase_b : pin_s2.phase_a)
                      ^ encoder_io_control[`QEI_IOC_APOL];
      phase_b_level = (encoder_io_control[`QEI_IOC_SWAP] ? pin_s2.phase_a : pin_s2.phase_b)
                      ^ encoder_io_control[`QEI_IOC_BPOL];
      index_level   = pin_s2.index ^ encoder_io_control[`QEI_IOC_IDXPOL];
      home_level    = pin_s2.home ^ encoder_io_control[`QEI_IOC_HOMPOL];
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pin_q <= '0;
         pin_l <= '0;
      end else begin
         pin_q <= '{home_level, index_level, phase_b_level, phase_a_level};
         pin_l <= pin_q;
      end
   end

   assign idx_rise  = pin_q.index & ~pin_l.index;
   assign home_rise = pin_q.home & ~pin_l.home;
   assign idx_match = (counter_control_mode == qei_pkg::QEI_CCM_QUAD)
                    && (encoder_control[`QEI_CTRL_IMV_HI:`QEI_CTRL_IMV_LO] != 2'b00)
                    && ({pin_q.phase_b, pin_q.phase_a}
                        == encoder_control[`QEI_CTRL_IMV_HI:`QEI_CTRL_IMV_LO]);

   // Enable, idle stop and gate together decide whether anything moves
   assign run = encoder_control[`QEI_CTRL_EN]
              & ~(encoder_control[`QEI_CTRL_SIDL] & cpu_idle)
              & ~(encoder_control[`QEI_CTRL_GATE] & ~gate_s2);

   // Timer prescaler; 2^n divide from prescale select
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !run) begin
         pre_cnt <= 8'h00;
      end else begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end
   always_comb begin
      logic [7:0] lim;
      lim = 8'h00;
      lim = 8'(({1'b0, 8'h01} << encoder_control[`QEI_CTRL_DIV_HI:`QEI_CTRL_DIV_LO]) - 9'h001);
      pre_tick = ((pre_cnt & lim) == lim);
   end

   // Step and direction per counter mode
   always_comb begin
      step   = 1'b0;
      dir_up = 1'b1;
      unique case (counter_control_mode)
         qei_pkg::QEI_CCM_QUAD: begin
            // Any edge of A or B steps; direction from the A/B order
            step   = (pin_q.phase_a ^ pin_l.phase_a) ^ (pin_q.phase_b ^ pin_l.phase_b);
            dir_up = pin_l.phase_a ^ pin_q.phase_b;
         end
         qei_pkg::QEI_CCM_EXTDIR: begin
            step   = pin_q.phase_a & ~pin_l.phase_a;
            dir_up = pin_q.phase_b;
         end
         qei_pkg::QEI_CCM_EXTCLK: begin
            step   = pin_q.phase_a & ~pin_l.phase_a;
            dir_up = ~pin_q.phase_b;
         end
         qei_pkg::QEI_CCM_TIMER: begin
            step   = pre_tick;
            dir_up = ~pin_q.phase_b;
         end
      endcase
      dir_up = dir_up ^ encoder_control[`QEI_CTRL_POL];
   end

   // Homing sequencer for init modes 011 and 100
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !run || counter_control_mode[1]) begin
         home_st <= qei_pkg::QEI_HS_WAIT;
      end else begin
         unique case (home_st)
            qei_pkg::QEI_HS_WAIT: if (home_rise) home_st <= qei_pkg::QEI_HS_IDX1;
            qei_pkg::QEI_HS_IDX1: if (idx_rise) home_st <= (pim == qei_pkg::QEI_PIM_HOME2)
                                                 ? qei_pkg::QEI_HS_IDX2 : qei_pkg::QEI_HS_WAIT;
            qei_pkg::QEI_HS_IDX2: if (idx_rise) home_st <= qei_pkg::QEI_HS_WAIT;
         endcase
      end
   end

   // Init-mode decisions; timer modes disregard the init field
   always_comb begin
      do_clear = 1'b0;
      do_load  = 1'b0;
      if (run && !counter_control_mode[1]) begin
         unique case (pim)
            qei_pkg::QEI_PIM_EVERY:   do_clear = idx_rise;
            qei_pkg::QEI_PIM_NEXT:    do_clear = idx_rise & armed;
            qei_pkg::QEI_PIM_HOMEIDX: do_load = idx_rise && home_st == qei_pkg::QEI_HS_IDX1;
            qei_pkg::QEI_PIM_HOME2:   do_load = idx_rise && home_st == qei_pkg::QEI_HS_IDX2;
            qei_pkg::QEI_PIM_CMP:     do_clear = 1'b0;
            qei_pkg::QEI_PIM_MOD:     do_clear = 1'b0;
            default:                  do_clear = 1'b0;
         endcase
         do_clear = do_clear | idx_match;
      end
   end
   assign next_flag_pci = do_load
                        && (pim == qei_pkg::QEI_PIM_HOMEIDX || pim == qei_pkg::QEI_PIM_HOME2);

   // Reset-on-next-index arms on a write to the control word
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         armed <= 1'b0;
      end else if (reg_wr && reg_addr == `QEI_OFS_CTRL) begin
         armed <= 1'b1;
      end else if (do_clear) begin
         armed <= 1'b0;
      end
   end

   // Position counter; software writes win over counting
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         position_counter <= 32'h0000_0000;
      end else if (reg_wr && reg_addr == `QEI_OFS_POSH) begin
         position_counter[31:16] <= reg_wdata;
      end else if (reg_wr && reg_addr == `QEI_OFS_POSL) begin
         position_counter[15:0] <= reg_wdata;
      end else if (do_load) begin
         position_counter <= init_capture_register;
      end else if (do_clear) begin
         position_counter <= 32'h0000_0000;
      end else if (run && step) begin
         position_counter <= dir_up ? position_counter + 32'h0000_0001
                                    : position_counter - 32'h0000_0001;
      end
   end
   assign position_high_word = position_counter[31:16];

   // Init value register kept internal; cleared at reset only
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         init_capture_register <= 32'h0000_0000;
      end
   end

   // Control registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         encoder_control    <= `QEI_CTRL_RST;
         encoder_io_control <= `QEI_IOC_RST;
         irq_mask           <= 16'hFFFF;
      end else if (reg_wr) begin
         if (reg_addr == `QEI_OFS_CTRL) encoder_control <= reg_wdata & 16'hBF7F;
         if (reg_addr == `QEI_OFS_IOC)  encoder_io_control <= reg_wdata & `QEI_IOC_WMASK;
         if (reg_addr == `QEI_OFS_IRQMASK) irq_mask <= reg_wdata;
      end
   end

   // Status: flags write-one-to-clear, set wins; enables plain read/write
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         encoder_status <= `QEI_STAT_RST;
      end else begin
         if (reg_wr && reg_addr == `QEI_OFS_STAT) begin
            encoder_status <= ((encoder_status & ~reg_wdata & `QEI_STAT_FLAGS)
                              | (reg_wdata & ~`QEI_STAT_FLAGS)) & `QEI_STAT_WMASK;
         end
         if (run && idx_rise) encoder_status[`QEI_ST_IDX] <= 1'b1;
         if (run && home_rise) encoder_status[`QEI_ST_HOM] <= 1'b1;
         if (next_flag_pci) encoder_status[`QEI_ST_PCI] <= 1'b1;
      end
   end

   // Level irq: flag and its enable and the mask all set
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(encoder_status & (encoder_status << 1) & `QEI_STAT_FLAGS
                  & irq_mask);
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `QEI_OFS_CTRL:    reg_rdata <= encoder_control;
            `QEI_OFS_IOC:     reg_rdata <= {encoder_io_control[15:4],
                                            pin_q.home, pin_q.index,
                                            pin_q.phase_b, pin_q.phase_a};
            `QEI_OFS_STAT:    reg_rdata <= encoder_status;
            `QEI_OFS_POSH:    reg_rdata <= position_high_word;
            `QEI_OFS_POSL:    reg_rdata <= position_counter[15:0];
            `QEI_OFS_IRQMASK: reg_rdata <= irq_mask;
            default:          reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Checks
   sequence s_idx_edge;
      run && idx_rise;
   endsequence
   AST_IDX_FLAG: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_idx_edge |=> encoder_status[`QEI_ST_IDX]) else $error("index flag not set");
   AST_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !encoder_control[`QEI_CTRL_EN] && !reg_wr |=> $stable(position_counter))
      else $error("counter moved while disabled");
   AST_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
      encoder_control[`QEI_CTRL_SIDL] && cpu_idle && !reg_wr |=> $stable(position_counter))
      else $error("counter moved in idle");
   AST_GATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
      encoder_control[`QEI_CTRL_GATE] && !gate_s2 && !reg_wr |=> $stable(position_counter))
      else $error("counter moved while gated");
   AST_MATCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
      run && idx_match && !reg_wr && !do_load |=> position_counter == 32'h0000_0000)
      else $error("index match did not clear");
   AST_UP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      run && step && counter_control_mode == qei_pkg::QEI_CCM_TIMER && !encoder_control[`QEI_CTRL_POL]
      && !reg_wr && !do_clear && !do_load && !pin_q.phase_b
      |=> position_counter == $past(position_counter) + 32'h0000_0001)
      else $error("timer did not count up");
   AST_PCI: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(encoder_status[`QEI_ST_PCI]) |-> $past(next_flag_pci))
      else $error("reinit flag without reinit");
   AST_IRQ: assert property (@(posedge sys_clk) disable iff (sys_rst)
      encoder_status[`QEI_ST_IDX] && encoder_status[`QEI_ST_IDXEN] && irq_mask[`QEI_ST_IDX]
      |=> irq) else $error("irq missing");
   AST_RDLAT: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reg_rd && reg_addr == `QEI_OFS_POSH && !reg_wr && !step
      |=> reg_rdata == $past(position_counter[31:16])) else $error("high word read wrong");
   AST_IRQ_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !encoder_status[`QEI_ST_IDX] && !encoder_status[`QEI_ST_HOM]
      && !encoder_status[`QEI_ST_PCI] |=> !irq) else $error("irq without flag");
   AST_MASK_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq_mask == 16'h0000 |=> !irq) else $error("irq while masked");
   AST_FLAG_CLR: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr == `QEI_OFS_STAT && reg_wdata[`QEI_ST_IDX] && !(run && idx_rise)
      |=> !encoder_status[`QEI_ST_IDX]) else $error("index flag not cleared");
   AST_QUAD_A: assert property (@(posedge sys_clk) disable iff (sys_rst)
      run && counter_control_mode == qei_pkg::QEI_CCM_QUAD && pin_q.phase_a != pin_l.phase_a
      && pin_q.phase_b == pin_l.phase_b && !reg_wr && !do_clear && !do_load
      |=> position_counter != $past(position_counter)) else $error("A edge not counted");
   AST_EXT_UP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      run && counter_control_mode == qei_pkg::QEI_CCM_EXTDIR && $rose(pin_q.phase_a) && pin_q.phase_b
      && !encoder_control[`QEI_CTRL_POL] && !reg_wr && !do_clear && !do_load
      |=> position_counter == $past(position_counter) + 32'h0000_0001)
      else $error("external up count wrong");
   AST_POL_QUAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
      run && counter_control_mode == qei_pkg::QEI_CCM_QUAD && encoder_control[`QEI_CTRL_POL]
      && $fell(pin_q.phase_a) && !pin_q.phase_b && !pin_l.phase_b
      && !reg_wr && !do_clear && !do_load
      |=> position_counter == $past(position_counter) - 32'h0000_0001)
      else $error("inverted direction wrong");
   AST_TIMER_PIM: assert property (@(posedge sys_clk) disable iff (sys_rst)
      run && counter_control_mode[1] && idx_rise && !step && !reg_wr |=> $stable(position_counter))
      else $error("timer mode used init field");
   AST_SWAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      encoder_io_control[`QEI_IOC_SWAP] |=> pin_q.phase_a
      == ($past(pin_s2.phase_b) ^ $past(encoder_io_control[`QEI_IOC_APOL])))
      else $error("swap not applied");
   AST_IDX_LEVEL: assert property (@(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> pin_q.index
      == ($past(pin_s2.index) ^ $past(encoder_io_control[`QEI_IOC_IDXPOL])))
      else $error("index level wrong");
   // Homing reloads only after the home edge and the right index edge
   sequence s_after_home;
      run && !counter_control_mode[1] && pim == qei_pkg::QEI_PIM_HOMEIDX && home_st == qei_pkg::QEI_HS_IDX1;
   endsequence
   sequence s_after_home2;
      run && !counter_control_mode[1] && pim == qei_pkg::QEI_PIM_HOME2 && home_st == qei_pkg::QEI_HS_IDX2;
   endsequence
   sequence s_idx_no_write;
      idx_rise && !reg_wr;
   endsequence
   AST_HOME_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_after_home ##0 s_idx_no_write |=> position_counter == 32'h0000_0000
      && encoder_status[`QEI_ST_PCI]) else $error("home index did not reload");
   AST_HOME2_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_after_home2 ##0 s_idx_no_write |=> encoder_status[`QEI_ST_PCI])
      else $error("second index did not reload");
endmodule : qei_core

// ---- verif/qei_enc_model.sv ----
// Partner model: incremental encoder with gray-coded A/B, index and home.
// Assumes the bench paces step requests; one phase moves per step.
`timescale 1ns/100ps
module qei_enc_model (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Commands from the bench
   input  wire logic step,
   input  wire logic up,
   input  wire logic idx,
   input  wire logic hom,
   // Encoder lines
   output logic      pha,
   output logic      phb,
   output logic      index_out,
   output logic      home_out
);
   logic [1:0] gray_pos;
   // Gray order, so a glitch-free single edge per step
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         gray_pos <= 2'h0;
      end else if (step) begin
         gray_pos <= up ? gray_pos + 2'h1 : gray_pos - 2'h1;
      end
   end
   assign pha       = gray_pos[1];
   assign phb       = gray_pos[1] ^ gray_pos[0];
   assign index_out = idx;
   assign home_out  = hom;
endmodule : qei_enc_model

// ---- verif/qei_core_tb_top.sv ----
// Testbench of the encoder block: register tasks and encoder stimulus.
// Assumes the map header offsets and one-cycle read data.
`timescale 1ns/100ps
`include "qei_map.svh"
module qei_core_tb_top;
   logic                   sys_clk    = 1'b0;
   logic                   sys_rst    = 1'b1;
   logic [`QEI_ADDR_W-1:0] reg_addr   = 4'h0;
   logic [15:0]            reg_wdata  = 16'h0000;
   logic                   reg_wr     = 1'b0;
   logic                   reg_rd     = 1'b0;
   logic                   cpu_idle   = 1'b0;
   logic                   gate_input = 1'b1;
   logic                   step       = 1'b0;
   logic                   up         = 1'b1;
   logic                   idx        = 1'b0;
   logic                   hom        = 1'b0;
   logic [15:0]            reg_rdata;
   logic                   pha, phb, index_pin, home_pin, irq;
   logic [15:0]            v1, v2;
   logic [15:0]            tctl [2]   = '{16'h8003, 16'h8033};
   logic [15:0]            tdel [2]   = '{16'h0010, 16'h0002};
   int                     n_mismatch = 0;
   int                     num_checks = 0;
   int                     cyc        = 0;
   int                     gst        = 0;
   always #12.5 sys_clk = ~sys_clk;
   qei_enc_model enc_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .step(step), .up(up),
      .idx(idx), .hom(hom), .pha(pha), .phb(phb), .index_out(index_pin),
      .home_out(home_pin));
   qei_core dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cpu_idle(cpu_idle), .phase_a_input(pha), .phase_b_input(phb),
      .index_input(index_pin), .home_input(home_pin), .gate_input(gate_input), .irq(irq));
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdv(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rdv
   task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      logic [15:0] v;
      rdv(a, v);
      chk(v & m, e);
   endtask : rd
   task automatic irq_is(input logic e);
      repeat (3) @(posedge sys_clk);
      #1 chk({15'h0000, irq}, {15'h0000, e});
   endtask : irq_is
   task automatic steps(input int n, input logic dir);
      repeat (n) begin
         @(posedge sys_clk);
         step <= 1'b1;
         up   <= dir;
         @(posedge sys_clk);
         step <= 1'b0;
         gst = (gst + (dir ? 1 : 3)) % 4;
         // Slow stepping keeps the count rate well under the clock
         repeat (8) @(posedge sys_clk);
      end
   endtask : steps
   task automatic pulse(input logic h);
      @(posedge sys_clk);
      if (h) hom <= 1'b1;
      else idx <= 1'b1;
      repeat (4) @(posedge sys_clk);
      hom <= 1'b0;
      idx <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask : pulse
   task automatic zero();
      wr(`QEI_OFS_POSH, 16'h0000);
      wr(`QEI_OFS_POSL, 16'h0000);
   endtask : zero
   always @(posedge sys_clk) begin
      cyc++;
      // Whole run needs somewhat over a thousand cycles
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(`QEI_OFS_CTRL, 16'hFFFF, `QEI_CTRL_RST);
      rd(`QEI_OFS_IOC, 16'hFFFF, `QEI_IOC_RST);
      rd(`QEI_OFS_STAT, 16'hFFFF, `QEI_STAT_RST);
      rd(`QEI_OFS_POSH, 16'hFFFF, 16'h0000);
      rd(`QEI_OFS_IRQMASK, 16'hFFFF, 16'hFFFF);
      rd(4'hF, 16'hFFFF, 16'h0000);
      wr(`QEI_OFS_CTRL, 16'hFFFF);
      rd(`QEI_OFS_CTRL, 16'hFFFF, 16'hBF7F);
      wr(`QEI_OFS_CTRL, 16'h0000);
      zero();
      wr(`QEI_OFS_CTRL, 16'h8000);
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0004);
      steps(5, 1'b0);
      rd(`QEI_OFS_POSH, 16'hFFFF, 16'hFFFF);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'hFFFF);
      wr(`QEI_OFS_CTRL, 16'h8008);
      steps(1, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'hFFFE);
      wr(`QEI_OFS_POSH, 16'h1234);
      rd(`QEI_OFS_POSH, 16'hFFFF, 16'h1234);
      wr(`QEI_OFS_CTRL, 16'h0000);
      zero();
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0000);
      wr(`QEI_OFS_CTRL, 16'hA000);
      cpu_idle <= 1'b1;
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0000);
      cpu_idle <= 1'b0;
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0004);
      wr(`QEI_OFS_CTRL, 16'h8000);
      cpu_idle <= 1'b1;
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0008);
      cpu_idle <= 1'b0;
      gate_input <= 1'b0;
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h000C);
      wr(`QEI_OFS_CTRL, 16'h8004);
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h000C);
      gate_input <= 1'b1;
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0010);
      zero();
      wr(`QEI_OFS_CTRL, 16'h8402);
      steps(8, 1'b1);
      pulse(1'b0);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'hFFFE);
      rd(`QEI_OFS_STAT, 16'h0002, 16'h0002);
      wr(`QEI_OFS_CTRL, 16'h8401);
      steps(4, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'hFFFF);
      steps(4, 1'b0);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'hFFFE);
      pulse(1'b0);
      rd(`QEI_OFS_POSH, 16'hFFFF, 16'h0000);
      wr(`QEI_OFS_STAT, 16'h0001);
      irq_is(1'b1);
      wr(`QEI_OFS_IRQMASK, 16'h0000);
      irq_is(1'b0);
      wr(`QEI_OFS_IRQMASK, 16'hFFFF);
      irq_is(1'b1);
      wr(`QEI_OFS_STAT, 16'h0003);
      irq_is(1'b0);
      rd(`QEI_OFS_STAT, 16'hFFFF, 16'h0001);
      pulse(1'b0);
      irq_is(1'b1);
      wr(`QEI_OFS_STAT, 16'h0000);
      irq_is(1'b0);
      wr(`QEI_OFS_STAT, 16'h0002);
      wr(`QEI_OFS_CTRL, 16'h0000);
      // Phase B low before timing, so the timer runs upward
      steps((4 - gst) % 4, 1'b1);
      for (int i = 0; i < 2; i++) begin
         wr(`QEI_OFS_CTRL, tctl[i]);
         rdv(`QEI_OFS_POSL, v1);
         repeat (14) @(posedge sys_clk);
         rdv(`QEI_OFS_POSL, v2);
         chk(v2 - v1, tdel[i]);
      end
      wr(`QEI_OFS_CTRL, 16'h0000);
      zero();
      wr(`QEI_OFS_CTRL, 16'h8300);
      steps(2, 1'b1);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0000);
      wr(`QEI_OFS_CTRL, 16'h0000);
      steps(2, 1'b1);
      wr(`QEI_OFS_IOC, 16'h00F0);
      rd(`QEI_OFS_IOC, 16'hFFFF, 16'h00FF);
      steps(3, 1'b1);
      wr(`QEI_OFS_IOC, 16'h0100);
      rd(`QEI_OFS_IOC, 16'hFFFF, 16'h0102);
      wr(`QEI_OFS_IOC, 16'h0000);
      zero();
      wr(`QEI_OFS_CTRL, 16'h8800);
      steps(4, 1'b1);
      pulse(1'b0);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0000);
      steps(4, 1'b1);
      pulse(1'b0);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0004);
      wr(`QEI_OFS_STAT, 16'h0082);
      wr(`QEI_OFS_CTRL, 16'h8C00);
      pulse(1'b1);
      pulse(1'b0);
      rd(`QEI_OFS_STAT, 16'h0080, 16'h0080);
      rd(`QEI_OFS_POSL, 16'hFFFF, 16'h0000);
      wr(`QEI_OFS_STAT, 16'h0080);
      wr(`QEI_OFS_CTRL, 16'h8000);
      pulse(1'b1);
      pulse(1'b0);
      rd(`QEI_OFS_STAT, 16'h0080, 16'h0000);
      wr(`QEI_OFS_CTRL, 16'h9000);
      pulse(1'b1);
      pulse(1'b0);
      rd(`QEI_OFS_STAT, 16'h0080, 16'h0000);
      pulse(1'b0);
      rd(`QEI_OFS_STAT, 16'h0080, 16'h0080);
      final_report();
   end
endmodule : qei_core_tb_top
